// ---- rtl/supervision_pkg.sv ----
// Constants and types shared by the relay self-supervision design
package supervision_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned WD_TIMEOUT_MS = 100;
   localparam int unsigned BOOT_TIMEOUT_MS = 500;
   localparam int unsigned SELFTEST_PERIOD_MS = 1000;
   localparam int unsigned RESTART_PULSE_US = 10;
   localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned BOOT_TIMEOUT_CYC =
      BOOT_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned SELFTEST_PERIOD_CYC =
      SELFTEST_PERIOD_MS * (CLK_HZ / 1000);
   localparam int unsigned RESTART_PULSE_CYC =
      RESTART_PULSE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W = 27;

   // ------------------------------------------------------------
   // Diagnostic register map (read select index)
   // ------------------------------------------------------------
   localparam logic [1:0] DIAG_SEL_OUTPUT = 2'h0;
   localparam logic [1:0] DIAG_SEL_SELFTEST = 2'h1;
   localparam logic [1:0] DIAG_SEL_SPARE = 2'h2;
   localparam logic [1:0] DIAG_SEL_HARDWARE = 2'h3;
   localparam int unsigned DIAG_W = 16;
   localparam logic [DIAG_W-1:0] DIAG_RESET = 16'h0000;

   // output_fault_diag fields
   localparam int unsigned OFD_DOUT_LSB = 2;
   localparam int unsigned NUM_DOUT = 7;
   localparam int unsigned OFD_ALARM_BIT = 10;

   // hardware_fault_diag fields
   localparam int unsigned HFD_SUPPLY_BIT = 0;
   localparam int unsigned HFD_BUS_BUF_BIT = 1;
   localparam int unsigned HFD_ORDER_BIT = 2;
   localparam int unsigned HFD_OPTION_BIT = 3;

   // self-test diagnostic field
   localparam int unsigned STD_FAIL_BIT = 0;

   // Matrix alarm vector positions
   localparam int unsigned ALM_REMOTE = 0;
   localparam int unsigned ALM_EXT_IO = 1;
   localparam int unsigned ALM_PORT1 = 2;
   localparam int unsigned ALM_PORT2 = 3;
   localparam int unsigned ALM_DIAG1 = 4;
   localparam int unsigned ALM_DIAG2 = 5;
   localparam int unsigned ALM_DIAG3 = 6;
   localparam int unsigned ALM_PASSWORD = 7;
   localparam int unsigned ALM_W = 8;

   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_WAIT = 3'b001,
      ST_RUN = 3'b010,
      ST_RESTART = 3'b011,
      ST_PERM = 3'b100
   } wd_state_t;

endpackage

// ---- rtl/sup_timer.sv ----
// Loadable down counter used for watchdog and self-test timing
`timescale 1ns/10ps
module sup_timer
   import supervision_pkg::*;
(
   input wire logic i_clk,                 // System clock
   input wire logic i_rst_n,               // Async reset, active low
   input wire logic i_load,                // Load the counter
   input wire logic [CNT_W-1:0] i_load_val, // Value to load
   output logic o_zero                     // Counter has reached zero
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (i_load) begin
         cnt_nxt = i_load_val;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Zero flag looks at the count only, so a load fed back from it
   // cannot form a combinational loop
   assign o_zero = (cnt_r == '0);

endmodule

// ---- rtl/relay_self_supervision.sv ----
// Relay self-supervision: watchdog, fault latching and output blocking
//
// What this block does
// R1 - Watch processor independently, restart it when stalled
// R2 - Failed restart raises permanent fault indication
// R3 - Permanent fault blocks other digital outputs
// R4 - Supply out of range is a fault
// R5 - Device-fail output energised while healthy
// R6 - Permanent fault de-energises device-fail output
// R7 - Service indicator follows device-fail fault exactly
// R8 - Provide routable matrix alarm signals
// R9 - Self-test at boot and periodically after
// R10 - Unhandled main functions enter permanent state
// R11 - Temporary fault sets signal, on/off events
// R12 - Latched diagnostics clear only by panel reset
// R13 - Four 16-bit readable diagnostic registers
// R14 - Output register: output faults 2-8, alarm 10
// R15 - Hardware register: supply, buffer, order, option
// R16 - Fault code travels with events and panel
// R17 - Unassigned bits read zero, no writes
// R18 - Processor must kick watchdog within timeout
`timescale 1ns/10ps
module relay_self_supervision
   import supervision_pkg::*;
#(
   parameter int unsigned WD_CYC = WD_TIMEOUT_CYC,
   parameter int unsigned BOOT_CYC = BOOT_TIMEOUT_CYC,
   parameter int unsigned SELFTEST_CYC = SELFTEST_PERIOD_CYC
) (
   input wire logic i_clk,                   // System clock, 125 MHz
   input wire logic i_rst_n,                 // Power-on reset, active low
   input wire logic i_wd_kick,               // Processor service pulse
   input wire logic i_supply_fault,          // Rail monitor pin, async
   input wire logic [NUM_DOUT-1:0] i_dout_fault, // Output fault pins, async
   input wire logic i_alarm_out_fault,       // Alarm output fault pin, async
   input wire logic i_bus_buffer_error,      // Bus buffer error
   input wire logic i_order_code_error,      // Order code mismatch
   input wire logic i_option_card_error,     // Option card error
   input wire logic i_selftest_fail,         // Self-test reported failure
   input wire logic i_main_func_lost,        // Main functions not handled
   input wire logic [NUM_DOUT-1:0] i_dout_cmd, // Digital output commands
   input wire logic i_diag_reset,            // Front-panel diag reset pulse
   input wire logic i_remote_comm_inactive,  // Remote comm inactive
   input wire logic i_ext_io_inactive,       // Extension I/O comm inactive
   input wire logic i_port1_down,            // Comm port one down
   input wire logic i_port2_down,            // Comm port two down
   input wire logic i_password_open,         // Password open
   input wire logic [1:0] i_diag_sel,        // Diagnostic register select
   output logic [DIAG_W-1:0] o_diag_data,    // Selected diagnostic register
   output logic [NUM_DOUT-1:0] o_dout,       // Gated digital outputs
   output logic o_proc_reset,                // Processor restart, active high
   output logic o_device_fail_output,        // High = relay energised
   output logic o_service_led,               // Service indicator on
   output logic o_display_fault_req,         // Local display fault message
   output logic o_temp_fault,                // Self-diagnostic matrix signal
   output logic o_temporary_fault_on_event,  // Fault-on event pulse
   output logic o_temporary_fault_off_event, // Fault-off event pulse
   output logic [2*DIAG_W-1:0] o_event_code, // Hardware and output codes
   output logic o_selftest_req,              // Self-test request pulse
   output logic [ALM_W-1:0] o_alarm          // Matrix alarm signals
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   localparam int unsigned PIN_W = NUM_DOUT + 2;
   logic [PIN_W-1:0] pin_meta_r;
   logic [PIN_W-1:0] pin_sync_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= {i_supply_fault, i_alarm_out_fault, i_dout_fault};
         pin_sync_r <= pin_meta_r;
      end
   end

   logic supply_fault_s;
   logic alarm_fault_s;
   logic [NUM_DOUT-1:0] dout_fault_s;
   assign {supply_fault_s, alarm_fault_s, dout_fault_s} = pin_sync_r;

   // ------------------------------------------------------------
   // Watchdog state machine
   // ------------------------------------------------------------
   wd_state_t state_r;
   wd_state_t state_nxt;
   logic wd_load;
   logic [CNT_W-1:0] wd_load_val;
   logic wd_zero;
   logic restarted_r;
   logic restarted_nxt;

   sup_timer u_wd_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_load(wd_load),
      .i_load_val(wd_load_val),
      .o_zero(wd_zero)
   );

   always_comb begin
      state_nxt = state_r;
      wd_load = 1'b0;
      wd_load_val = CNT_W'(WD_CYC);
      restarted_nxt = restarted_r;
      case (state_r)
         ST_BOOT: begin
            wd_load = 1'b1;
            wd_load_val = CNT_W'(BOOT_CYC);
            state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            if (i_main_func_lost) begin
               state_nxt = ST_PERM;                   // see R10
            end else if (i_wd_kick) begin
               wd_load = 1'b1;
               state_nxt = ST_RUN;
            end else if (wd_zero) begin
               if (restarted_r) begin
                  state_nxt = ST_PERM;                // see R2
               end else begin
                  wd_load = 1'b1;
                  wd_load_val = CNT_W'(RESTART_PULSE_CYC);
                  state_nxt = ST_RESTART;
               end
            end
         end
         ST_RUN: begin
            if (i_main_func_lost) begin
               state_nxt = ST_PERM;                   // see R10
            end else if (i_wd_kick) begin
               wd_load = 1'b1;                        // see R18
               restarted_nxt = 1'b0;
            end else if (wd_zero) begin
               wd_load = 1'b1;                        // see R1
               wd_load_val = CNT_W'(RESTART_PULSE_CYC);
               state_nxt = ST_RESTART;
            end
         end
         ST_RESTART: begin
            if (wd_zero) begin
               wd_load = 1'b1;
               wd_load_val = CNT_W'(BOOT_CYC);
               restarted_nxt = 1'b1;
               state_nxt = ST_WAIT;
            end
         end
         ST_PERM: begin
            state_nxt = ST_PERM;
         end
         default: begin
            state_nxt = ST_PERM;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ST_BOOT;
         restarted_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         restarted_r <= restarted_nxt;
      end
   end

   // ------------------------------------------------------------
   // Self-test scheduling
   // ------------------------------------------------------------
   logic st_zero;
   logic st_load;
   logic st_req_r;
   logic st_req_nxt;

   sup_timer u_selftest_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_load(st_load),
      .i_load_val(CNT_W'(SELFTEST_CYC)),
      .o_zero(st_zero)
   );

   always_comb begin
      st_load = (state_r == ST_BOOT) || st_zero;
      st_req_nxt = st_load && (state_r != ST_PERM);   // see R9
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_req_r <= 1'b0;
      end else begin
         st_req_r <= st_req_nxt;
      end
   end

   // ------------------------------------------------------------
   // Diagnostic latches and events
   // ------------------------------------------------------------
   logic [DIAG_W-1:0] ofd_live;
   logic [DIAG_W-1:0] hfd_live;
   logic [DIAG_W-1:0] std_live;
   logic [DIAG_W-1:0] ofd_r;
   logic [DIAG_W-1:0] ofd_nxt;
   logic [DIAG_W-1:0] hfd_r;
   logic [DIAG_W-1:0] hfd_nxt;
   logic [DIAG_W-1:0] std_r;
   logic [DIAG_W-1:0] std_nxt;
   logic live_r;
   logic live_nxt;
   logic on_ev_r;
   logic on_ev_nxt;
   logic off_ev_r;
   logic off_ev_nxt;
   logic [2*DIAG_W-1:0] code_r;
   logic [2*DIAG_W-1:0] code_nxt;

   always_comb begin
      ofd_live = '0;
      ofd_live[OFD_DOUT_LSB +: NUM_DOUT] = dout_fault_s;  // see R14
      ofd_live[OFD_ALARM_BIT] = alarm_fault_s;            // see R14
      hfd_live = '0;
      hfd_live[HFD_SUPPLY_BIT] = supply_fault_s;          // see R4, R15
      hfd_live[HFD_BUS_BUF_BIT] = i_bus_buffer_error;     // see R15
      hfd_live[HFD_ORDER_BIT] = i_order_code_error;       // see R15
      hfd_live[HFD_OPTION_BIT] = i_option_card_error;     // see R15
      std_live = '0;
      std_live[STD_FAIL_BIT] = i_selftest_fail;
      // Reset clears, but a fault present in that cycle stays set
      ofd_nxt = (i_diag_reset ? DIAG_RESET : ofd_r) | ofd_live; // see R12
      hfd_nxt = (i_diag_reset ? DIAG_RESET : hfd_r) | hfd_live; // see R12
      std_nxt = (i_diag_reset ? DIAG_RESET : std_r) | std_live; // see R12
      live_nxt = |{ofd_live, hfd_live, std_live};
      on_ev_nxt = live_nxt && !live_r;                    // see R11
      off_ev_nxt = !live_nxt && live_r;                   // see R11
      code_nxt = code_r;
      if (on_ev_nxt || off_ev_nxt) begin
         code_nxt = {hfd_nxt, ofd_nxt};                   // see R16
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ofd_r <= DIAG_RESET;
         hfd_r <= DIAG_RESET;
         std_r <= DIAG_RESET;
         live_r <= 1'b0;
         on_ev_r <= 1'b0;
         off_ev_r <= 1'b0;
         code_r <= '0;
      end else begin
         ofd_r <= ofd_nxt;
         hfd_r <= hfd_nxt;
         std_r <= std_nxt;
         live_r <= live_nxt;
         on_ev_r <= on_ev_nxt;
         off_ev_r <= off_ev_nxt;
         code_r <= code_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs: blocking, device-fail, alarms, register read
   // ------------------------------------------------------------
   logic perm_r;
   logic perm_nxt;
   logic [NUM_DOUT-1:0] dout_r;
   logic [NUM_DOUT-1:0] dout_nxt;
   logic [ALM_W-1:0] alarm_r;
   logic [ALM_W-1:0] alarm_nxt;
   logic [DIAG_W-1:0] rd_r;
   logic [DIAG_W-1:0] rd_nxt;

   always_comb begin
      perm_nxt = (state_nxt == ST_PERM);
      dout_nxt = perm_nxt ? '0 : i_dout_cmd;              // see R3
      alarm_nxt = '0;
      alarm_nxt[ALM_REMOTE] = i_remote_comm_inactive;     // see R8
      alarm_nxt[ALM_EXT_IO] = i_ext_io_inactive;
      alarm_nxt[ALM_PORT1] = i_port1_down;
      alarm_nxt[ALM_PORT2] = i_port2_down;
      alarm_nxt[ALM_DIAG1] = |ofd_r;
      alarm_nxt[ALM_DIAG2] = |std_r;
      alarm_nxt[ALM_DIAG3] = |hfd_r;
      alarm_nxt[ALM_PASSWORD] = i_password_open;
      case (i_diag_sel)                                   // see R13, R17
         DIAG_SEL_OUTPUT: rd_nxt = ofd_r;
         DIAG_SEL_SELFTEST: rd_nxt = std_r;
         DIAG_SEL_HARDWARE: rd_nxt = hfd_r;
         default: rd_nxt = '0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         perm_r <= 1'b0;
         dout_r <= '0;
         alarm_r <= '0;
         rd_r <= DIAG_RESET;
      end else begin
         perm_r <= perm_nxt;
         dout_r <= dout_nxt;
         alarm_r <= alarm_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign o_dout = dout_r;
   assign o_proc_reset = (state_r == ST_RESTART);           // see R1
   assign o_device_fail_output = !perm_r;                   // see R5, R6
   assign o_service_led = perm_r;                           // see R7
   assign o_display_fault_req = perm_r;                     // see R10
   assign o_temp_fault = |{ofd_r, hfd_r, std_r};            // see R11
   assign o_temporary_fault_on_event = on_ev_r;
   assign o_temporary_fault_off_event = off_ev_r;
   assign o_event_code = code_r;
   assign o_selftest_req = st_req_r;
   assign o_alarm = alarm_r;
   assign o_diag_data = rd_r;

endmodule

// ---- verification/sup_chk.sv ----
// Assertion checker for the relay self-supervision block
`timescale 1ns/10ps
module sup_chk
   import supervision_pkg::*;
#(
   parameter int unsigned WD_CYC = 40,
   parameter int unsigned BOOT_CYC = 60,
   parameter int unsigned SELFTEST_CYC = 100
) (
   input wire logic i_clk, // clock
   input wire logic i_rst_n, // reset
   input wire logic i_supply_fault, // rail fault
   input wire logic i_main_func_lost, // main loss
   input wire logic [NUM_DOUT-1:0] i_dout_cmd, // commands
   input wire logic i_diag_reset, // panel reset
   input wire logic i_remote_comm_inactive, // remote
   input wire logic i_ext_io_inactive, // ext io
   input wire logic i_port1_down, // port 1
   input wire logic i_port2_down, // port 2
   input wire logic i_password_open, // password
   input wire logic [NUM_DOUT-1:0] o_dout, // outputs
   input wire logic o_proc_reset, // restart
   input wire logic o_device_fail_output, // fail relay
   input wire logic o_service_led, // led
   input wire logic o_display_fault_req, // display
   input wire logic o_temp_fault, // diag flag
   input wire logic o_temporary_fault_on_event, // on event
   input wire logic o_temporary_fault_off_event, // off event
   input wire logic o_selftest_req, // self-test
   input wire logic [ALM_W-1:0] o_alarm // alarms
);
   // Restart pulse stands for the loaded count plus the zero cycle
   localparam logic [11:0] PULSE_LEN = 12'(RESTART_PULSE_CYC + 1);
   // ---------------------------------
   // Restart pulse length counter
   // ---------------------------------
   logic [11:0] rst_cnt_r;
   logic [11:0] rst_cnt_nxt;
   always_comb begin
      rst_cnt_nxt = o_proc_reset ? rst_cnt_r + 12'h001 : 12'h000;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_cnt_r <= 12'h000;
      end else begin
         rst_cnt_r <= rst_cnt_nxt;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // ---------------------------------
   // Assertions
   // ---------------------------------
   a_led_tracks_fail: assert property (
      o_service_led == !o_device_fail_output) else $error("led mismatch");
   a_display_with_led: assert property (
      o_display_fault_req == o_service_led) else $error("display mismatch");
   a_perm_blocks_dout: assert property (
      !o_device_fail_output |-> o_dout == '0) else $error("outputs not off");
   a_dout_follows_cmd: assert property (
      $past(i_rst_n) && o_device_fail_output |-> o_dout == $past(i_dout_cmd))
      else $error("output not following command");
   a_fail_sticky: assert property (
      !o_device_fail_output |=> !o_device_fail_output)
      else $error("fail output re-energised");
   a_restart_len: assert property (
      $fell(o_proc_reset) |-> rst_cnt_r == PULSE_LEN)
      else $error("restart pulse length");
   a_restart_bound: assert property (
      o_proc_reset |-> rst_cnt_r < PULSE_LEN) else $error("restart too long");
   a_supply_flags: assert property (
      $rose(i_supply_fault) |-> ##[1:6] o_alarm[ALM_DIAG3])
      else $error("supply fault not flagged");
   a_alarm_passes: assert property (
      $past(i_rst_n) |-> {o_alarm[ALM_PASSWORD], o_alarm[ALM_PORT2],
      o_alarm[ALM_PORT1], o_alarm[ALM_EXT_IO], o_alarm[ALM_REMOTE]} ==
      $past({i_password_open, i_port2_down, i_port1_down,
      i_ext_io_inactive, i_remote_comm_inactive})) else $error("alarm");
   a_on_then_flag: assert property (
      o_temporary_fault_on_event |=> o_temp_fault &&
      !o_temporary_fault_on_event) else $error("on event");
   a_diag_holds: assert property (
      o_temp_fault && !i_diag_reset && !$past(i_diag_reset) |=> o_temp_fault)
      else $error("diag flag dropped");
   a_selftest_boot: assert property (
      $rose(i_rst_n) |-> ##[1:3] o_selftest_req) else $error("no self-test");
   a_main_loss_perm: assert property (
      i_main_func_lost && !o_proc_reset && $past(i_rst_n) |->
      ##[1:3] !o_device_fail_output) else $error("no permanent state");
   cover property ($fell(o_proc_reset));
   cover property ($fell(o_device_fail_output));
   cover property (o_temporary_fault_off_event);
endmodule

bind relay_self_supervision sup_chk #(.WD_CYC(WD_CYC),
   .BOOT_CYC(BOOT_CYC), .SELFTEST_CYC(SELFTEST_CYC)) i_sup_chk (.*);

// ---- verification/mcu_model.sv ----
// Behavioural model of the supervised processor servicing the watchdog
`timescale 1ns/10ps
module mcu_model #(
   parameter int unsigned KICK_GAP = 10
) (
   input wire logic i_clk, // clock
   input wire logic i_rst_n, // reset
   input wire logic i_proc_reset, // restart
   input wire logic i_stall, // program hung
   output logic o_wd_kick // service pulse
);
   int unsigned gap;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap <= 0;
         o_wd_kick <= 1'b0;
      end else if (i_proc_reset || i_stall) begin
         gap <= 0;
         o_wd_kick <= 1'b0;
      end else begin
         gap <= (gap == KICK_GAP - 1) ? 0 : gap + 1;
         o_wd_kick <= (gap == KICK_GAP - 1);
      end
   end
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench for the relay self-supervision block
`timescale 1ns/10ps
module tb;
   import supervision_pkg::*;
   logic i_clk, i_rst_n, i_wd_kick, stall, i_diag_reset, i_main_func_lost;
   logic i_supply_fault, i_alarm_out_fault, i_bus_buffer_error;
   logic i_order_code_error, i_option_card_error, i_selftest_fail;
   logic i_remote_comm_inactive, i_ext_io_inactive, i_port1_down;
   logic i_port2_down, i_password_open;
   logic [NUM_DOUT-1:0] i_dout_fault, i_dout_cmd, o_dout;
   logic [1:0] i_diag_sel;
   logic [DIAG_W-1:0] o_diag_data, d;
   logic o_proc_reset, o_device_fail_output, o_service_led;
   logic o_display_fault_req, o_temp_fault, o_selftest_req;
   logic o_temporary_fault_on_event, o_temporary_fault_off_event;
   logic [2*DIAG_W-1:0] o_event_code, ev_code;
   logic [ALM_W-1:0] o_alarm;
   logic [12:0] flt;
   logic [4:0] alm;
   int bad_count, cmp_count, cyc, on_cnt, off_cnt, t0, st_cnt;
   assign {i_selftest_fail, i_option_card_error, i_order_code_error,
      i_bus_buffer_error, i_supply_fault, i_alarm_out_fault,
      i_dout_fault} = flt;
   assign {i_password_open, i_port2_down, i_port1_down, i_ext_io_inactive,
      i_remote_comm_inactive} = alm;
   relay_self_supervision #(.WD_CYC(40), .BOOT_CYC(60),
      .SELFTEST_CYC(100)) i_relay_self_supervision (.*);
   mcu_model #(.KICK_GAP(10)) i_mcu_model (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_proc_reset(o_proc_reset), .i_stall(stall),
      .o_wd_kick(i_wd_kick));
   // ---------------------------------
   // Clock, timeout and event capture
   // ---------------------------------
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (o_temporary_fault_on_event === 1'b1) begin
         on_cnt++;
         ev_code = o_event_code;
      end
      if (o_temporary_fault_off_event === 1'b1) off_cnt++;
      if (o_selftest_req === 1'b1) st_cnt++;
      if (cyc == 12000) begin
         bad_count++;
         final_report();
      end
   end
   // ---------------------------------
   // Tasks
   // ---------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic rd(input logic [1:0] s, output logic [15:0] v);
      @(posedge i_clk) i_diag_sel <= s;
      wt(2);
      v = o_diag_data;
   endtask
   task automatic clr();
      @(posedge i_clk) i_diag_reset <= 1'b1;
      @(posedge i_clk) i_diag_reset <= 1'b0;
      wt(4);
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   function automatic logic [1:0] fsel(input int k);
      if (k < 8) return DIAG_SEL_OUTPUT;
      if (k < 12) return DIAG_SEL_HARDWARE;
      return DIAG_SEL_SELFTEST;
   endfunction
   function automatic logic [15:0] fbit(input int k);
      if (k < 7) return 16'h0001 << (k + OFD_DOUT_LSB);
      if (k == 7) return 16'h0001 << OFD_ALARM_BIT;
      if (k < 12) return 16'h0001 << (k - 8);
      return 16'h0001 << STD_FAIL_BIT;
   endfunction
   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial begin
      {i_rst_n, stall, i_diag_reset, i_main_func_lost} = 4'h0;
      {flt, alm, i_dout_cmd, i_diag_sel} = 27'h0000000;
      wt(8);
      @(posedge i_clk) i_rst_n <= 1'b1;
      wt(3);
      chk(o_device_fail_output, 1'b1);
      for (int s = 0; s < 4; s++) begin
         rd(s[1:0], d);
         chk(d, 16'h0000);
      end
      for (int p = 0; p < 2; p++) begin
         @(posedge i_clk) alm <= p ? 5'h0A : 5'h15;
         i_dout_cmd <= p ? 7'h2A : 7'h55;
         wt(2);
         chk({o_alarm[ALM_PASSWORD], o_alarm[ALM_PORT2:ALM_REMOTE]},
            p ? 5'h0A : 5'h15);
         chk(o_dout, p ? 7'h2A : 7'h55);
      end
      for (int k = 0; k < 13; k++) begin
         @(posedge i_clk) flt[k] <= 1'b1;
         wt(8);
         rd(fsel(k), d);
         chk(d, fbit(k));
         chk(o_temp_fault, 1'b1);
         chk(o_alarm[k < 8 ? ALM_DIAG1 : k < 12 ? ALM_DIAG3 : ALM_DIAG2],
            1'b1);
         rd(DIAG_SEL_SPARE, d);
         chk(d, 16'h0000);
         chk(on_cnt, k + 1);
         if (k < 12) begin
            chk(ev_code, k < 8 ? {16'h0000, fbit(k)}
               : {fbit(k), 16'h0000});
         end
         clr();
         rd(fsel(k), d);
         chk(d, fbit(k));
         @(posedge i_clk) flt[k] <= 1'b0;
         wt(8);
         chk(off_cnt, k + 1);
         rd(fsel(k), d);
         chk(d, fbit(k));
         clr();
         rd(fsel(k), d);
         chk(d, 16'h0000);
         chk(o_temp_fault, 1'b0);
      end
      chk(st_cnt > 3, 1'b1);
      t0 = cyc;
      @(posedge i_clk) stall <= 1'b1;
      @(posedge i_clk iff o_proc_reset === 1'b1);
      chk(cyc - t0 < 60, 1'b1);
      stall <= 1'b0;
      @(posedge i_clk iff o_proc_reset === 1'b0);
      wt(200);
      chk({o_device_fail_output, o_proc_reset}, 2'h2);
      @(posedge i_clk) stall <= 1'b1;
      @(posedge i_clk iff o_proc_reset === 1'b1);
      @(posedge i_clk iff o_proc_reset === 1'b0);
      t0 = cyc;
      @(posedge i_clk iff o_device_fail_output === 1'b0);
      chk(cyc - t0 < 66, 1'b1);
      stall <= 1'b0;
      i_dout_cmd <= 7'h7F;
      wt(100);
      chk({o_device_fail_output, o_service_led, o_display_fault_req},
         3'h3);
      chk({o_dout, o_proc_reset}, 8'h00);
      @(posedge i_clk) i_dout_cmd <= 7'h00;
      i_rst_n <= 1'b0;
      wt(8);
      @(posedge i_clk) i_rst_n <= 1'b1;
      wt(4);
      chk({o_device_fail_output, o_service_led}, 2'h2);
      @(posedge i_clk) i_main_func_lost <= 1'b1;
      wt(4);
      chk({o_device_fail_output, o_service_led}, 2'h1);
      final_report();
   end
endmodule
